// >>> hdl/secchk_defs.svh
// Error codes, encodings and register map constants of the error checker.
`ifndef SECCHK_DEFS_SVH
`define SECCHK_DEFS_SVH
// Error codes as shown on the display.
`define SECCHK_E_NONE   6'h00
`define SECCHK_E_PV1    6'h01
`define SECCHK_E_PV2    6'h02
`define SECCHK_E_DEP    6'h03
`define SECCHK_E_COOL   6'h04
`define SECCHK_E_UNIT   6'h05
`define SECCHK_E_AL2    6'h06
`define SECCHK_E_DWELL  6'h07
`define SECCHK_E_FUNC   6'h0a
`define SECCHK_E_ADDR   6'h0b
`define SECCHK_E_PARAM  6'h0c
`define SECCHK_E_RO     6'h0e
`define SECCHK_E_RANGE  6'h0f
// Process value source codes.
`define SECCHK_PV_IN1   3'h0
`define SECCHK_PV_IN2   3'h1
`define SECCHK_PV_1M2   3'h2
`define SECCHK_PV_2M1   3'h3
// Setpoint source codes.
`define SECCHK_SP_LOCAL 3'h0
`define SECCHK_SP_IN1   3'h1
`define SECCHK_SP_IN2   3'h2
// Output one action.
`define SECCHK_O1_REVERSE 1'h0
`define SECCHK_O1_DIRECT  1'h1
// Output two use.
`define SECCHK_O2_AL2   2'h0
`define SECCHK_O2_COOL  2'h1
`define SECCHK_O2_OFF   2'h2
// Alarm functions.
`define SECCHK_AF_NONE  4'h0
`define SECCHK_AF_DWELL_TIMER_FUNCTION  4'h1
`define SECCHK_AF_DPH   4'h2
`define SECCHK_AF_DPL   4'h3
`define SECCHK_AF_DDH   4'h4
`define SECCHK_AF_DDL   4'h5
// Request function codes.
`define SECCHK_FN_READ  8'h03
`define SECCHK_FN_WRITE 8'h06
// Register map of the link slave.
`define SECCHK_EXIST    16'hefff
`define SECCHK_RO       16'hc000
`define SECCHK_REG_SE   4'he
`define SECCHK_REG_CE   4'hf
`define SECCHK_WR_MAX   16'h270f
`define SECCHK_ZERO16   16'h0000
`endif

// >>> hdl/secchk_pkg.sv
// Types shared by the error checker modules.
package secchk_pkg;
    typedef logic [5:0] secchk_code_t;
    typedef struct packed {
        logic [2:0]  process_value_source_sel;
        logic [2:0]  setpoint_source_sel;
        logic        first_output_cfg;
        logic [1:0]  second_output_cfg;
        logic [15:0] prop_band_a;
        logic [15:0] prop_band_b;
        logic [15:0] integral_time_a;
        logic [15:0] integral_time_b;
        logic [1:0]  input_one_unit;
        logic [1:0]  input_two_unit;
        logic [1:0]  input_one_decimal_point;
        logic [1:0]  input_two_decimal_point;
        logic [3:0]  alarm_one_function;
        logic [3:0]  alarm_two_function;
    } secchk_setup_t;
    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] data;
    } secchk_req_t;
    typedef struct packed {
        secchk_code_t err;
        logic [15:0]  data;
    } secchk_rsp_t;
endpackage : secchk_pkg

// >>> hdl/secchk_req.sv
// Request checker and parameter store of the serial link slave.
`timescale 1ns/1ps
`include "secchk_defs.svh"

module secchk_req
    import secchk_pkg::*;
#(
    parameter int              NREG  = 16,
    parameter logic [NREG-1:0] EXIST = `SECCHK_EXIST,
    parameter logic [NREG-1:0] RO    = `SECCHK_RO
)
(
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Request in.
    input  wire logic         req_valid,
    input  wire secchk_req_t  req,
    // Status words seen through the read-only registers.
    input  wire secchk_code_t status_setup,
    input  wire secchk_code_t status_comm,
    // Answer out.
    output logic              rsp_valid,
    output secchk_rsp_t       rsp
);
    localparam int AW = $clog2(NREG);
    logic [15:0]   mem      [NREG];
    logic [15:0]   next_mem [NREG];
    logic          next_rsp_valid;
    secchk_rsp_t   next_rsp;
    logic [AW-1:0] idx;
    logic          wr;
    logic          func_ok;
    logic          in_range;

    // Decode of the request fields.
    assign idx      = req.addr[AW-1:0];
    assign wr       = (req.func == `SECCHK_FN_WRITE);
    assign func_ok  = wr || (req.func == `SECCHK_FN_READ);
    assign in_range = (req.addr < 16'(NREG));

    // Check the request; the first failing check names the code.
    always_comb
    begin
        next_rsp_valid = req_valid;
        next_rsp       = rsp;
        next_mem       = mem;
        if (req_valid)
        begin
            next_rsp.data = `SECCHK_ZERO16;
            if (!func_ok)
                next_rsp.err = `SECCHK_E_FUNC; // RQ8
            else if (!in_range)
                next_rsp.err = `SECCHK_E_ADDR; // RQ9
            else if (!EXIST[idx])
                next_rsp.err = `SECCHK_E_PARAM; // RQ10
            else if (wr && RO[idx])
                next_rsp.err = `SECCHK_E_RO; // RQ11
            else if (wr && (req.data > `SECCHK_WR_MAX))
                next_rsp.err = `SECCHK_E_RANGE; // RQ13
            else
            begin
                next_rsp.err = `SECCHK_E_NONE;
                if (wr)
                    next_mem[idx] = req.data;
                else if (idx == AW'(`SECCHK_REG_SE))
                    next_rsp.data = 16'(status_setup);
                else if (idx == AW'(`SECCHK_REG_CE))
                    next_rsp.data = 16'(status_comm);
                else
                    next_rsp.data = mem[idx];
            end
        end
    end

    // Register the answer and the store.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
            for (int i = 0; i < NREG; i++)
                mem[i] <= `SECCHK_ZERO16;
        end
        else
        begin
            rsp_valid <= next_rsp_valid;
            rsp       <= next_rsp;
            mem       <= next_mem;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_bad_func_code: assert property (req_valid && !func_ok |=> rsp_valid && rsp.err == `SECCHK_E_FUNC) // RQ8
        else $error("bad function code not reported");
    a_addr_range: assert property (req_valid && func_ok && !in_range |=> rsp.err == `SECCHK_E_ADDR) // RQ9
        else $error("out of range address not reported");
    a_param_missing: assert property (req_valid && func_ok && in_range && !EXIST[idx]
                                      |=> rsp.err == `SECCHK_E_PARAM) // RQ10
        else $error("missing parameter not reported");
    a_ro_write_kept: assert property (req_valid && wr && in_range && EXIST[idx] && RO[idx]
                                      |=> rsp.err == `SECCHK_E_RO) // RQ11
        else $error("read-only write not refused");
    a_write_range: assert property (req_valid && wr && in_range && EXIST[idx] && !RO[idx]
                                    && req.data > `SECCHK_WR_MAX
                                    |=> rsp.err == `SECCHK_E_RANGE) // RQ13
        else $error("over range write not refused");
endmodule : secchk_req

// >>> hdl/secchk_top.sv
// Top of the setup and request error checker.
`timescale 1ns/1ps
`include "secchk_defs.svh"

// How it works
// (RQ1) Input one as both process value and setpoint source gives code 1.
// (RQ2) Input two as both process value and setpoint source gives code 2.
// (RQ3) Input difference as process value with single input setpoint gives code 3.
// (RQ4) Output two cooling with output one direct or not PID gives code 4.
// (RQ5) Unit or decimal mismatch while inputs are combined gives code 5.
// (RQ6) Output two on alarm two with no alarm function gives code 6, no drive.
// (RQ7) Dwell timer on both alarms gives code 7.
// (RQ8) Unsupported function code is rejected with code 10.
// (RQ9) Register address beyond the map is rejected with code 11.
// (RQ10) Request to a missing parameter is rejected with code 12.
// (RQ11) Write to read-only data is refused with code 14, value kept.
// (RQ12) The master should not write read-only or protected data.
// (RQ13) Write value above the register limit is refused with code 15.
// (RQ14) Latest error code stays on the output until reset or correction.
module secchk_top
    import secchk_pkg::*;
#(
    parameter int NREG = 16
)
(
    // Clock and reset.
    input  wire logic          REF_CLK,
    input  wire logic          RST_N,
    // Stored setup from the parameter store.
    input  wire secchk_setup_t SETUP,
    // Alarm two decision from the alarm logic.
    input  wire logic          ALARM_TWO_RAW,
    // Request from the serial link slave.
    input  wire logic          REQ_VALID,
    input  wire secchk_req_t   REQ,
    // Answer to the serial link slave.
    output logic               RSP_VALID,
    output secchk_rsp_t        RSP,
    // Error reporting.
    output secchk_code_t       SETUP_ERR,
    output secchk_code_t       COMM_ERR,
    output secchk_code_t       ERR_CODE,
    // Output two alarm drive.
    output logic               SECOND_OUTPUT_CFG_ALARM
);
    // Setup fault flags, one per setup error code.
    logic [7:1]   fl;
    logic         pv_diff;
    logic         sp_input;
    logic         al_diff;
    logic         pid_off;
    secchk_code_t setup_err;
    secchk_code_t next_setup_err;
    secchk_code_t comm_err;
    secchk_code_t next_comm_err;
    secchk_code_t err_code;
    secchk_code_t next_err_code;
    logic         second_output_cfg_alarm;
    logic         next_second_output_cfg_alarm;
    logic         rsp_valid;
    secchk_rsp_t  rsp;

    // True for the alarm functions that combine both inputs.
    function automatic logic is_diff_alarm(input logic [3:0] f);
        return (f == `SECCHK_AF_DPH) || (f == `SECCHK_AF_DPL) ||
               (f == `SECCHK_AF_DDH) || (f == `SECCHK_AF_DDL);
    endfunction : is_diff_alarm

    // True when a tuning term is zero, which takes the loop out of PID form.
    function automatic logic is_zero(input logic [15:0] v);
        return v == `SECCHK_ZERO16;
    endfunction : is_zero

    // Classify the setup and raise one flag per illegal combination.
    always_comb
    begin
        pv_diff  = (SETUP.process_value_source_sel == `SECCHK_PV_1M2) ||
                   (SETUP.process_value_source_sel == `SECCHK_PV_2M1);
        sp_input = (SETUP.setpoint_source_sel == `SECCHK_SP_IN1) ||
                   (SETUP.setpoint_source_sel == `SECCHK_SP_IN2);
        al_diff  = is_diff_alarm(SETUP.alarm_one_function) ||
                   is_diff_alarm(SETUP.alarm_two_function);
        pid_off  = is_zero(SETUP.prop_band_a) || is_zero(SETUP.prop_band_b) ||
                   is_zero(SETUP.integral_time_a) || is_zero(SETUP.integral_time_b);
        // Input one feeds both sides of the loop.
        fl[1] = (SETUP.process_value_source_sel == `SECCHK_PV_IN1) &&
                (SETUP.setpoint_source_sel == `SECCHK_SP_IN1); // RQ1
        // Input two feeds both sides of the loop.
        fl[2] = (SETUP.process_value_source_sel == `SECCHK_PV_IN2) &&
                (SETUP.setpoint_source_sel == `SECCHK_SP_IN2); // RQ2
        // Dependent values on process value and setpoint.
        fl[3] = pv_diff && sp_input; // RQ3
        // Cooling on output two needs reverse action and PID on output one.
        fl[4] = (SETUP.second_output_cfg == `SECCHK_O2_COOL) &&
                ((SETUP.first_output_cfg == `SECCHK_O1_DIRECT) || pid_off); // RQ4
        // Combined inputs must agree in unit and decimal point.
        fl[5] = ((SETUP.input_one_unit != SETUP.input_two_unit) ||
                 (SETUP.input_one_decimal_point != SETUP.input_two_decimal_point)) &&
                (pv_diff || sp_input || al_diff); // RQ5
        // Output two assigned to an alarm that has no function.
        fl[6] = (SETUP.second_output_cfg == `SECCHK_O2_AL2) &&
                (SETUP.alarm_two_function == `SECCHK_AF_NONE); // RQ6
        // The dwell timer serves one alarm only.
        fl[7] = (SETUP.alarm_one_function == `SECCHK_AF_DWELL_TIMER_FUNCTION) &&
                (SETUP.alarm_two_function == `SECCHK_AF_DWELL_TIMER_FUNCTION); // RQ7
    end

    // Next values: lowest setup code wins, link code kept until next answer.
    always_comb
    begin
        if (fl[1])
            next_setup_err = `SECCHK_E_PV1;
        else if (fl[2])
            next_setup_err = `SECCHK_E_PV2;
        else if (fl[3])
            next_setup_err = `SECCHK_E_DEP;
        else if (fl[4])
            next_setup_err = `SECCHK_E_COOL;
        else if (fl[5])
            next_setup_err = `SECCHK_E_UNIT;
        else if (fl[6])
            next_setup_err = `SECCHK_E_AL2;
        else if (fl[7])
            next_setup_err = `SECCHK_E_DWELL;
        else
            next_setup_err = `SECCHK_E_NONE;
        // A clean answer corrects the link fault, a faulty one replaces it.
        next_comm_err = rsp_valid ? rsp.err : comm_err; // RQ14
        // Setup faults take the display first, since they stop normal control.
        next_err_code = (setup_err != `SECCHK_E_NONE) ? setup_err : comm_err; // RQ14
        // Output two follows alarm two only when the alarm has a function.
        next_second_output_cfg_alarm = ALARM_TWO_RAW && !fl[6] &&
                          (SETUP.second_output_cfg == `SECCHK_O2_AL2); // RQ6
    end

    // Error and drive registers.
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            setup_err  <= `SECCHK_E_NONE;
            comm_err   <= `SECCHK_E_NONE;
            err_code   <= `SECCHK_E_NONE;
            second_output_cfg_alarm <= 1'b0;
        end
        else
        begin
            setup_err  <= next_setup_err;
            comm_err   <= next_comm_err;
            err_code   <= next_err_code;
            second_output_cfg_alarm <= next_second_output_cfg_alarm;
        end
    end

    // Request checking and the register store sit in the link slave.
    secchk_req #(
        .NREG         (NREG)
    ) u_req (
        .clk          (REF_CLK),
        .rst_n        (RST_N),
        .req_valid    (REQ_VALID),
        .req          (REQ),
        .status_setup (setup_err),
        .status_comm  (comm_err),
        .rsp_valid    (rsp_valid),
        .rsp          (rsp)
    );

    // Outputs straight from registers.
    assign RSP_VALID  = rsp_valid;
    assign RSP        = rsp;
    assign SETUP_ERR  = setup_err;
    assign COMM_ERR   = comm_err;
    assign ERR_CODE   = err_code;
    assign SECOND_OUTPUT_CFG_ALARM = second_output_cfg_alarm;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // A valid answer that carries an error code.
    sequence s_comm_fault;
        RSP_VALID && (RSP.err != `SECCHK_E_NONE);
    endsequence

    sequence s_setup_clean;
        SETUP_ERR == `SECCHK_E_NONE;
    endsequence

    a_pv1_both: assert property (fl[1] |=> SETUP_ERR == `SECCHK_E_PV1) // RQ1
        else $error("input one double use not reported");

    a_pv2_both: assert property (fl[2] && !fl[1] |=> SETUP_ERR == `SECCHK_E_PV2) // RQ2
        else $error("input two double use not reported");

    a_dep_values: assert property (fl[3] && !(|fl[2:1]) |=> SETUP_ERR == `SECCHK_E_DEP) // RQ3
        else $error("dependent sources not reported");

    a_cool_conflict: assert property (SETUP.second_output_cfg == `SECCHK_O2_COOL
                                      && is_zero(SETUP.prop_band_a) && !(|fl[3:1])
                                      |=> SETUP_ERR == `SECCHK_E_COOL) // RQ4
        else $error("cooling conflict not reported");

    a_unit_match: assert property (fl[5] && !(|fl[4:1]) |=> SETUP_ERR == `SECCHK_E_UNIT) // RQ5
        else $error("unit mismatch not reported");

    a_al2_gated: assert property (fl[6] |=> !SECOND_OUTPUT_CFG_ALARM
                                  && (SETUP_ERR == `SECCHK_E_AL2 || $past(|fl[5:1]))) // RQ6
        else $error("alarm two without function still driven");

    a_dwell_both: assert property (fl[7] && !(|fl[6:1]) |=> SETUP_ERR == `SECCHK_E_DWELL) // RQ7
        else $error("double dwell timer not reported");

    // A legal alarm two assignment passes the alarm decision through.
    a_second_output_cfg_follow: assert property (SETUP.second_output_cfg == `SECCHK_O2_AL2 && !fl[6]
                                    |=> SECOND_OUTPUT_CFG_ALARM == $past(ALARM_TWO_RAW)) // RQ6
        else $error("output two does not follow alarm two");

    // Every request gets exactly one answer pulse on the next edge.
    a_rsp_pulse: assert property (REQ_VALID |=> RSP_VALID) // RQ8
        else $error("request left without an answer");

    a_comm_latest: assert property (s_comm_fault ##1 s_setup_clean
                                    |=> ERR_CODE == $past(RSP.err, 2)) // RQ14
        else $error("link error code not shown");

    a_comm_hold: assert property (!RSP_VALID |=> $stable(COMM_ERR)) // RQ14
        else $error("link error code changed without an answer");

    a_setup_first: assert property (SETUP_ERR != `SECCHK_E_NONE
                                    |=> ERR_CODE == $past(SETUP_ERR)) // RQ14
        else $error("setup error not shown first");
endmodule : secchk_top

// >>> tb/secchk_master.sv
// Link master model that issues one request and collects its answer.
`timescale 1ns/1ps
`include "secchk_defs.svh"

module secchk_master
    import secchk_pkg::*;
(
    // Clock.
    input  wire logic        clk,
    // Request out.
    output logic             req_valid,
    output secchk_req_t      req,
    // Answer in.
    input  wire logic        rsp_valid,
    input  wire secchk_rsp_t rsp
);
    // Idle request lines at time zero.
    initial
    begin
        req_valid = 1'h0;
        req       = '0;
    end

    // One request pulse; the answer is taken while it stands, then the lines are scrambled.
    task automatic send(input logic [7:0] func, input logic [15:0] addr,
                        input logic [15:0] data, input logic ro_ok,
                        output logic seen, output secchk_rsp_t got);
        @(negedge clk);
        // Writes to the status words go out only when the bench asks for them.
        if (func == `SECCHK_FN_WRITE && addr[15:1] == 15'h0007 && !ro_ok)
            func = `SECCHK_FN_READ;
        req_valid = 1'h1;
        req       = '{func, addr, data};
        @(negedge clk);
        // The answer pulse stands for the cycle after the taking edge only.
        seen      = rsp_valid;
        got       = rsp;
        req_valid = 1'h0;
        req       = ~req;
    endtask : send
endmodule : secchk_master

// >>> tb/tb.sv
// Self-checking bench of the setup and request error checker.
`timescale 1ns/1ps
`include "secchk_defs.svh"

`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end

module tb
    import secchk_pkg::*;
;
    logic          clk = 1'h0;
    logic          rst_n = 1'h0;
    secchk_setup_t setup;
    logic          raw = 1'h0;
    logic          req_valid;
    secchk_req_t   req;
    logic          rsp_valid;
    secchk_rsp_t   rsp;
    secchk_code_t  setup_err;
    secchk_code_t  comm_err;
    secchk_code_t  err_code;
    logic          second_output_cfg_alarm;
    int            failures = 0;
    int            check_count = 0;
    int            cycles = 0;

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    secchk_top #(.NREG(16)) dut (.REF_CLK(clk), .RST_N(rst_n), .SETUP(setup),
        .ALARM_TWO_RAW(raw), .REQ_VALID(req_valid), .REQ(req), .RSP_VALID(rsp_valid),
        .RSP(rsp), .SETUP_ERR(setup_err), .COMM_ERR(comm_err), .ERR_CODE(err_code),
        .SECOND_OUTPUT_CFG_ALARM(second_output_cfg_alarm));

    secchk_master m (.clk(clk), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp));

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            summarize();
        end
    end

    // A clean setup with every check passing.
    function automatic secchk_setup_t base();
        secchk_setup_t s;
        s = '0;
        s.second_output_cfg = `SECCHK_O2_OFF;
        s.prop_band_a = 16'h0010;
        s.prop_band_b = 16'h0010;
        s.integral_time_a = 16'h0020;
        s.integral_time_b = 16'h0020;
        return s;
    endfunction : base

    // Applies a setup and checks the codes two edges later.
    task automatic sc(input secchk_setup_t s, input secchk_code_t e);
        @(negedge clk);
        setup = s;
        repeat (2) @(negedge clk);
        `CHK(setup_err, e)
        if (e != `SECCHK_E_NONE)
            `CHK(err_code, e)
    endtask : sc

    // Issues one request and checks the answer and the held codes.
    task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      input logic ro, input secchk_code_t e, input logic [15:0] x);
        logic        seen;
        secchk_rsp_t got;
        m.send(f, a, d, ro, seen, got);
        `CHK(seen, 1'h1)
        `CHK(got.err, e)
        if (f == `SECCHK_FN_READ)
            `CHK(got.data, x)
        @(negedge clk);
        `CHK(comm_err, e)
        @(negedge clk);
        `CHK(err_code, e)
    endtask : rq

    task automatic src(input logic [2:0] pv, input logic [2:0] sp, input secchk_code_t e);
        secchk_setup_t s;
        s = base();
        s.process_value_source_sel = pv;
        s.setpoint_source_sel = sp;
        sc(s, e);
    endtask : src

    task automatic t_src();
        src(`SECCHK_PV_IN1, `SECCHK_SP_IN1, `SECCHK_E_PV1);
        src(`SECCHK_PV_IN2, `SECCHK_SP_IN2, `SECCHK_E_PV2);
        src(`SECCHK_PV_1M2, `SECCHK_SP_IN1, `SECCHK_E_DEP);
        src(`SECCHK_PV_2M1, `SECCHK_SP_IN2, `SECCHK_E_DEP);
        src(`SECCHK_PV_1M2, `SECCHK_SP_LOCAL, `SECCHK_E_NONE);
    endtask : t_src

    task automatic t_cool();
        secchk_setup_t s;
        s = base();
        s.second_output_cfg = `SECCHK_O2_COOL;
        sc(s, `SECCHK_E_NONE);
        s.first_output_cfg = `SECCHK_O1_DIRECT;
        sc(s, `SECCHK_E_COOL);
        s.first_output_cfg = `SECCHK_O1_REVERSE;
        s.prop_band_a = 16'h0000;
        sc(s, `SECCHK_E_COOL);
        s.prop_band_a = 16'h0010;
        s.prop_band_b = 16'h0000;
        sc(s, `SECCHK_E_COOL);
        s.prop_band_b = 16'h0010;
        s.integral_time_a = 16'h0000;
        sc(s, `SECCHK_E_COOL);
    endtask : t_cool

    task automatic t_unit();
        secchk_setup_t s;
        for (int k = 2; k <= 5; k++)
        begin
            s = base();
            s.alarm_two_function = 4'(k);
            sc(s, `SECCHK_E_NONE);
            s.input_two_unit = 2'h1;
            sc(s, `SECCHK_E_UNIT);
        end
        s = base();
        s.process_value_source_sel = `SECCHK_PV_1M2;
        s.input_one_decimal_point = 2'h2;
        sc(s, `SECCHK_E_UNIT);
        s = base();
        s.setpoint_source_sel = `SECCHK_SP_IN2;
        s.input_one_unit = 2'h1;
        sc(s, `SECCHK_E_UNIT);
    endtask : t_unit

    task automatic t_al2();
        secchk_setup_t s;
        s = base();
        s.second_output_cfg = `SECCHK_O2_AL2;
        raw = 1'h1;
        sc(s, `SECCHK_E_AL2);
        `CHK(second_output_cfg_alarm, 1'h0)
        s.alarm_two_function = `SECCHK_AF_DPH;
        sc(s, `SECCHK_E_NONE);
        `CHK(second_output_cfg_alarm, 1'h1)
        raw = 1'h0;
        @(negedge clk);
        `CHK(second_output_cfg_alarm, 1'h0)
    endtask : t_al2

    task automatic t_dwell();
        secchk_setup_t s;
        s = base();
        s.alarm_one_function = `SECCHK_AF_DWELL_TIMER_FUNCTION;
        sc(s, `SECCHK_E_NONE);
        s.alarm_two_function = `SECCHK_AF_DWELL_TIMER_FUNCTION;
        sc(s, `SECCHK_E_DWELL);
        s.setpoint_source_sel = `SECCHK_SP_IN1;
        sc(s, `SECCHK_E_PV1);
        sc(base(), `SECCHK_E_NONE);
    endtask : t_dwell

    task automatic t_req();
        rq(`SECCHK_FN_WRITE, 16'h0003, 16'h0005, 1'h0, `SECCHK_E_NONE, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h0003, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h0005);
        rq(8'h10, 16'h0003, 16'h0001, 1'h0, `SECCHK_E_FUNC, 16'h0000);
        rq(8'h00, 16'h0003, 16'h0001, 1'h0, `SECCHK_E_FUNC, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h0010, 16'h0000, 1'h0, `SECCHK_E_ADDR, 16'h0000);
        rq(`SECCHK_FN_WRITE, 16'hffff, 16'h0001, 1'h0, `SECCHK_E_ADDR, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h000c, 16'h0000, 1'h0, `SECCHK_E_PARAM, 16'h0000);
        rq(`SECCHK_FN_WRITE, 16'h000e, 16'h0007, 1'h1, `SECCHK_E_RO, 16'h0000);
        rq(`SECCHK_FN_WRITE, 16'h000f, 16'h0007, 1'h1, `SECCHK_E_RO, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h000f, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h000e);
        rq(`SECCHK_FN_READ, 16'h000e, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h0000);
        rq(`SECCHK_FN_WRITE, 16'h0003, 16'h2710, 1'h0, `SECCHK_E_RANGE, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h0003, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h0005);
        rq(`SECCHK_FN_WRITE, 16'h0003, 16'h270f, 1'h0, `SECCHK_E_NONE, 16'h0000);
        rq(`SECCHK_FN_READ, 16'h0003, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h270f);
    endtask : t_req

    task automatic t_hold();
        secchk_setup_t s;
        rq(8'h41, 16'h0001, 16'h0000, 1'h0, `SECCHK_E_FUNC, 16'h0000);
        s = base();
        s.process_value_source_sel = `SECCHK_PV_IN2;
        s.setpoint_source_sel = `SECCHK_SP_IN2;
        sc(s, `SECCHK_E_PV2);
        sc(base(), `SECCHK_E_NONE);
        `CHK(err_code, `SECCHK_E_FUNC)
        rq(`SECCHK_FN_READ, 16'h0001, 16'h0000, 1'h0, `SECCHK_E_NONE, 16'h0000);
    endtask : t_hold

    // Main sequence.
    initial
    begin
        setup = base();
        setup.setpoint_source_sel = `SECCHK_SP_IN1;
        repeat (4) @(negedge clk);
        `CHK(setup_err, `SECCHK_E_NONE)
        rst_n = 1'h1;
        setup = base();
        t_src();
        t_cool();
        t_unit();
        t_al2();
        t_dwell();
        t_req();
        t_hold();
        summarize();
    end
endmodule : tb
